// file: rtl/mod_imm_pkg.sv
package mod_imm_pkg;

  // Instruction halfword and field widths
  localparam int HALF_W  = 16;
  localparam int WORD_W  = 32;
  localparam int PACK_W  = 12;
  localparam int OPSEL_W = 5;
  localparam int REG_W   = 4;

  // First halfword field positions
  localparam int HI_TOP_MSB   = 15;
  localparam int HI_TOP_LSB   = 11;
  localparam int HI_IMM_TOP   = 10;
  localparam int HI_PLAIN_BIT = 9;
  localparam int HI_OP_MSB    = 8;
  localparam int HI_OP_LSB    = 4;
  localparam int HI_SETS_BIT  = 4;
  localparam int HI_RN_MSB    = 3;
  localparam int HI_RN_LSB    = 0;

  // Second halfword field positions
  localparam int LO_CLASS_BIT = 15;
  localparam int LO_TRIP_MSB  = 14;
  localparam int LO_TRIP_LSB  = 12;
  localparam int LO_MID_MSB   = 7;
  localparam int LO_MID_LSB   = 6;
  localparam int LO_BYTE_MSB  = 7;

  // Packed field positions
  localparam int PK_ROT_MSB   = 11;
  localparam int PK_ROT_LSB   = 7;
  localparam int PK_MODE_MSB  = 11;
  localparam int PK_MODE_LSB  = 10;
  localparam int PK_REP_MSB   = 9;
  localparam int PK_REP_LSB   = 8;
  localparam int PK_LOW7_MSB  = 6;

  // Group identification patterns
  localparam logic [4:0] TOP_PATTERN   = 5'h1e;
  localparam logic [3:0] PC_REGISTER   = 4'hf;
  localparam logic [2:0] TRIPLET_ZERO  = 3'h0;
  localparam logic [1:0] MID_ZERO      = 2'h0;

  // Replication modes of the packed field
  localparam logic [1:0] MODE_PLAIN    = 2'h0;
  localparam logic [1:0] REP_BYTE      = 2'h0;
  localparam logic [1:0] REP_ODD       = 2'h1;
  localparam logic [1:0] REP_EVEN      = 2'h2;
  localparam logic [1:0] REP_ALL       = 2'h3;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // Modified immediate opcodes, upper four bits
  localparam logic [3:0] MI_AND = 4'h0;
  localparam logic [3:0] MI_BIC = 4'h1;
  localparam logic [3:0] MI_ORR = 4'h2;
  localparam logic [3:0] MI_ORN = 4'h3;
  localparam logic [3:0] MI_EOR = 4'h4;
  localparam logic [3:0] MI_ADD = 4'h8;
  localparam logic [3:0] MI_ADC = 4'ha;
  localparam logic [3:0] MI_SBC = 4'hb;
  localparam logic [3:0] MI_SUB = 4'hd;
  localparam logic [3:0] MI_RSB = 4'he;

  // Plain binary immediate opcodes
  localparam logic [4:0] PB_ADD_WIDE  = 5'h00;
  localparam logic [4:0] PB_MOVE_WIDE = 5'h04;
  localparam logic [4:0] PB_SUB_WIDE  = 5'h0a;
  localparam logic [4:0] PB_MOVE_TOP  = 5'h0c;
  localparam logic [4:0] PB_SSAT      = 5'h10;
  localparam logic [4:0] PB_SSAT_DUAL = 5'h12;
  localparam logic [4:0] PB_SIGNED_FIELD_EXTRACT      = 5'h14;
  localparam logic [4:0] PB_FIELD_INS = 5'h16;
  localparam logic [4:0] PB_USAT      = 5'h18;
  localparam logic [4:0] PB_USAT_DUAL = 5'h1a;
  localparam logic [4:0] PB_UNSIGNED_FIELD_EXTRACT      = 5'h1c;

  // Decoded operation class
  typedef enum logic [4:0] {
    CLS_NONE,
    CLS_LOGICAL,
    CLS_ARITH,
    CLS_ADD_WIDE,
    CLS_MOVE_WIDE,
    CLS_SUB_WIDE,
    CLS_MOVE_TOP,
    CLS_SIGNED_SAT,
    CLS_UNSIGNED_SAT,
    CLS_DUAL_SIGNED_SATURATE,
    CLS_DUAL_UNSIGNED_SATURATE,
    CLS_SIGNED_FIELD_EXTRACT,
    CLS_UNSIGNED_FIELD_EXTRACT,
    CLS_FIELD_INSERT,
    CLS_FIELD_CLEAR,
    CLS_UNDEFINED
  } op_class_t;

endpackage

// file: rtl/imm_expand.sv
`timescale 1ns/100ps
`default_nettype none

module imm_expand
  import mod_imm_pkg::*;
(
  // Packed field and incoming carry
  input  wire logic [PACK_W-1:0] packedImmediateField,
  input  wire logic              carryIn,
  // Expanded constant and carry-out
  output logic      [WORD_W-1:0] immConst,
  output logic                   immCarry,
  output logic                   unpredictable
);

  // Rotate right, carry is the new top bit
  function automatic logic [WORD_W-1:0] rotateRight(input logic [WORD_W-1:0] v,
                                                    input logic [4:0] n);
    logic [2*WORD_W-1:0] dbl;
    dbl = {v, v} >> n;
    return dbl[WORD_W-1:0];
  endfunction

  logic [7:0]        immByte;  // Low byte of the packed field
  logic [WORD_W-1:0] unrotated; // Leading one above seven bits

  assign immByte   = packedImmediateField[LO_BYTE_MSB:0];
  assign unrotated = {{(WORD_W-8){1'b0}}, 1'b1, packedImmediateField[PK_LOW7_MSB:0]};

  // Expansion and carry selection
  always_comb begin
    immConst      = '0;
    immCarry      = carryIn;
    unpredictable = 1'b0;
    if (packedImmediateField[PK_MODE_MSB:PK_MODE_LSB] == MODE_PLAIN) begin
      // Zero-extended and replicating forms; carry passes through
      case (packedImmediateField[PK_REP_MSB:PK_REP_LSB])
        REP_BYTE: begin
          immConst = {{(WORD_W-8){1'b0}}, immByte};
        end
        REP_ODD: begin
          immConst = {8'h00, immByte, 8'h00, immByte};
        end
        REP_EVEN: begin
          immConst = {immByte, 8'h00, immByte, 8'h00};
        end
        default: begin
          immConst = {immByte, immByte, immByte, immByte};
        end
      endcase
      // Zero byte in a replicating form is not a legal source word
      unprediction: begin
        unpredictable = (packedImmediateField[PK_REP_MSB:PK_REP_LSB] != REP_BYTE)
                        && (immByte == BYTE_ZERO);
      end
    end else begin
      // Rotated form; carry is bit 31 of the result
      immConst = rotateRight(unrotated,
                   packedImmediateField[PK_ROT_MSB:PK_ROT_LSB]);
      immCarry = immConst[WORD_W-1];
    end
  end

endmodule

`default_nettype wire

// file: rtl/modified_immediate_decoder.sv
// Function
// - Mode 0000x gives zero-extended byte
// - Mode 0001x fills bytes two and zero
// - Mode 0010x fills bytes three and one
// - Mode 0011x fills all four bytes
// - Otherwise rotate one-led byte by top five
// - Logical 00xxx selector keeps carry flag
// - Other logical selectors load constant bit 31
// - Dual saturate needs zero bits, signal variant
// - Field extract, insert or clear decoding
// - Unallocated plain immediate encodings are undefined
`timescale 1ns/100ps
`default_nettype none

module modified_immediate_decoder
  import mod_imm_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Instruction from fetch
  input  wire logic              instrValid,
  input  wire logic [HALF_W-1:0] instrHigh,
  input  wire logic [HALF_W-1:0] instrLow,
  // Core configuration and flags
  input  wire logic              dspVariant,
  input  wire logic              carryFlag,
  // Decoded result towards execute
  output logic                   decodeValid,
  output op_class_t              opClass,
  output logic      [WORD_W-1:0] immConst,
  output logic                   carryOut,
  output logic                   carryWrite,
  output logic                   undefinedInstr,
  output logic                   unpredictable,
  output logic      [REG_W-1:0]  firstOperandRegister
);

  // True for the bitwise logical opcodes of the modified group
  function automatic logic isLogical(input logic [OPSEL_W-1:0] op);
    logic [3:0] top4;
    top4 = op[OPSEL_W-1:1];
    return (top4 == MI_AND) || (top4 == MI_BIC) || (top4 == MI_ORR)
        || (top4 == MI_ORN) || (top4 == MI_EOR);
  endfunction

  // True for the arithmetic opcodes of the modified group
  function automatic logic isArith(input logic [OPSEL_W-1:0] op);
    logic [3:0] top4;
    top4 = op[OPSEL_W-1:1];
    return (top4 == MI_ADD) || (top4 == MI_ADC) || (top4 == MI_SBC)
        || (top4 == MI_SUB) || (top4 == MI_RSB);
  endfunction

  // Field extraction from the two halfwords
  logic [OPSEL_W-1:0] opSel;       // Five-bit opcode
  logic [REG_W-1:0]   rnField;     // First operand register
  logic [2:0]         immediateHighTriplet; // High immediate field
  logic [7:0]         immByte;     // Immediate byte
  logic [PACK_W-1:0]  packedImmediateField; // Assembled packed field
  logic               inTopSpace;  // Data-processing immediate space
  logic               isModified;  // Modified immediate group
  logic               isPlain;     // Plain binary immediate group
  logic               satBitsZero; // Second-halfword triplet and bits 7:6 zero
  logic [4:0]         carrySel;    // Top five bits of packed field

  assign opSel   = instrHigh[HI_OP_MSB:HI_OP_LSB];
  assign rnField = instrHigh[HI_RN_MSB:HI_RN_LSB];
  assign immediateHighTriplet = instrLow[LO_TRIP_MSB:LO_TRIP_LSB];
  assign immByte = instrLow[LO_BYTE_MSB:0];

  // Top bit, triplet, byte, most significant first
  assign packedImmediateField = {instrHigh[HI_IMM_TOP], immediateHighTriplet, immByte};

  // Both groups have bit 15 of the second halfword clear
  assign inTopSpace = (instrHigh[HI_TOP_MSB:HI_TOP_LSB] == TOP_PATTERN)
                      && !instrLow[LO_CLASS_BIT];
  assign isModified = inTopSpace && !instrHigh[HI_PLAIN_BIT];
  assign isPlain    = inTopSpace && instrHigh[HI_PLAIN_BIT];

  // Dual saturate needs these reserved bits clear
  assign satBitsZero = (immediateHighTriplet == TRIPLET_ZERO)
                       && (instrLow[LO_MID_MSB:LO_MID_LSB] == MID_ZERO);

  // Selector for the carry rule: top bit, triplet, byte msb
  assign carrySel = packedImmediateField[PACK_W-1:PACK_W-5];

  // Expander outputs
  logic [WORD_W-1:0] expConst;   // Expanded constant
  logic              expCarry;   // Carry-out of expansion
  logic              expUnpred;  // Zero byte in replicating mode

  // Constant expansion is shared by every modified opcode
  imm_expand imm_expand_inst (
    .packedImmediateField (packedImmediateField),
    .carryIn              (carryFlag),
    .immConst             (expConst),
    .immCarry             (expCarry),
    .unpredictable        (expUnpred)
  );

  // Next values of the registered decode
  logic              next_decodeValid;
  op_class_t         next_opClass;
  logic [WORD_W-1:0] next_immConst;
  logic              next_carryOut;
  logic              next_carryWrite;
  logic              next_undefinedInstr;
  logic              next_unpredictable;
  logic [REG_W-1:0]  next_firstOperandRegister;

  // Invalid cycles still refresh every output, so execute never
  // acts on a stale class; carry mirrors the flag unless rewritten
  // Decode of both immediate groups
  always_comb begin
    next_decodeValid          = instrValid;
    next_opClass              = CLS_NONE;
    next_immConst             = '0;
    next_carryOut             = carryFlag;
    next_carryWrite           = 1'b0;
    next_undefinedInstr       = 1'b0;
    next_unpredictable        = 1'b0;
    next_firstOperandRegister = rnField;
    if (!instrValid) begin
      // Hold outputs quiet between instructions
      next_firstOperandRegister = '0;
    end else if (isModified) begin
      next_immConst      = expConst;
      next_unpredictable = expUnpred;
      if (isLogical(opSel)) begin
        next_opClass    = CLS_LOGICAL;
        // Only flag-setting logical ops touch carry
        next_carryWrite = instrHigh[HI_SETS_BIT];
        if (carrySel[4:3] == MODE_PLAIN) begin
          next_carryOut = carryFlag;
        end else begin
          next_carryOut = expConst[WORD_W-1];
        end
      end else if (isArith(opSel)) begin
        // Arithmetic carry comes from the adder, not here
        next_opClass = CLS_ARITH;
      end else begin
        // Holes in the modified opcode map
        next_opClass        = CLS_UNDEFINED;
        next_undefinedInstr = 1'b1;
      end
    end else if (isPlain) begin
      // Plain constants are formed downstream from raw fields
      case (opSel)
        PB_ADD_WIDE:  next_opClass = CLS_ADD_WIDE;
        PB_MOVE_WIDE: next_opClass = CLS_MOVE_WIDE;
        PB_SUB_WIDE:  next_opClass = CLS_SUB_WIDE;
        PB_MOVE_TOP:  next_opClass = CLS_MOVE_TOP;
        PB_SSAT:      next_opClass = CLS_SIGNED_SAT;
        PB_USAT:      next_opClass = CLS_UNSIGNED_SAT;
        PB_SSAT_DUAL: begin
          // Single saturate is not allocated on this opcode
          if (satBitsZero && dspVariant) begin
            next_opClass = CLS_DUAL_SIGNED_SATURATE;
          end else begin
            next_opClass        = CLS_UNDEFINED;
            next_undefinedInstr = 1'b1;
          end
        end
        PB_USAT_DUAL: begin
          if (satBitsZero && dspVariant) begin
            next_opClass = CLS_DUAL_UNSIGNED_SATURATE;
          end else begin
            next_opClass        = CLS_UNDEFINED;
            next_undefinedInstr = 1'b1;
          end
        end
        PB_SIGNED_FIELD_EXTRACT: next_opClass = CLS_SIGNED_FIELD_EXTRACT;
        PB_UNSIGNED_FIELD_EXTRACT: next_opClass = CLS_UNSIGNED_FIELD_EXTRACT;
        PB_FIELD_INS: begin
          // All-ones operand register selects the clear form
          if (rnField == PC_REGISTER) begin
            next_opClass = CLS_FIELD_CLEAR;
          end else begin
            next_opClass = CLS_FIELD_INSERT;
          end
        end
        default: begin
          next_opClass        = CLS_UNDEFINED;
          next_undefinedInstr = 1'b1;
        end
      endcase
    end else begin
      // Outside this block's space; another decoder owns it
      next_opClass = CLS_NONE;
    end
  end

  // Quiet reset values; execute ignores them until decodeValid
  // Decode register; one stage of latency
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      decodeValid          <= 1'b0;
      opClass              <= CLS_NONE;
      immConst             <= '0;
      carryOut             <= 1'b0;
      carryWrite           <= 1'b0;
      undefinedInstr       <= 1'b0;
      unpredictable        <= 1'b0;
      firstOperandRegister <= '0;
    end else begin
      decodeValid          <= next_decodeValid;
      opClass              <= next_opClass;
      immConst             <= next_immConst;
      carryOut             <= next_carryOut;
      carryWrite           <= next_carryWrite;
      undefinedInstr       <= next_undefinedInstr;
      unpredictable        <= next_unpredictable;
      firstOperandRegister <= next_firstOperandRegister;
    end
  end

endmodule

`default_nettype wire

// file: tb/modified_immediate_decoder_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module modified_immediate_decoder_assertions
  import mod_imm_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Request side
  input  wire logic              instrValid,
  input  wire logic [HALF_W-1:0] instrHigh,
  input  wire logic [HALF_W-1:0] instrLow,
  input  wire logic              dspVariant,
  input  wire logic              carryFlag,
  // Result side
  input  wire logic              decodeValid,
  input  wire op_class_t         opClass,
  input  wire logic [WORD_W-1:0] immConst,
  input  wire logic              carryOut,
  input  wire logic              carryWrite,
  input  wire logic              undefinedInstr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Packed field, group hit and opcode of the request
  wire logic [PACK_W-1:0] pk = {instrHigh[10], instrLow[14:12], instrLow[7:0]};
  wire logic              grp = instrValid && instrHigh[15:11] == TOP_PATTERN && !instrLow[15];
  wire logic [4:0]        op = instrHigh[8:4];
  // Reference rotation, independent of the decoder body
  wire logic [WORD_W-1:0] base = {24'h0, 1'b1, pk[6:0]};
  wire logic [WORD_W-1:0] rotv = (base >> pk[11:7]) | (base << (6'd32 - {1'b0, pk[11:7]}));
  // Request classes
  sequence s_mod;
    grp && !instrHigh[9];
  endsequence
  sequence s_setlog;
    s_mod ##0 (instrHigh[4] && instrHigh[8:5] <= MI_EOR);
  endsequence
  sequence s_plain;
    grp && instrHigh[9];
  endsequence
  a_valid_follows: assert property (instrValid |=> decodeValid)
    else $error("decodeValid missing after request");
  a_idle_quiet: assert property (!instrValid |=> !decodeValid && opClass == CLS_NONE)
    else $error("result shown without request");
  a_zero_extend: assert property (
    s_mod ##0 pk[11:8] == 4'h0 |=> immConst == {24'h0, $past(instrLow[7:0])})
    else $error("zero extended constant wrong");
  a_byte_fill: assert property (
    s_mod ##0 pk[11:8] == 4'h3 |=> immConst == {4{$past(instrLow[7:0])}})
    else $error("replicated constant wrong");
  a_rotate_exact: assert property (
    s_mod ##0 pk[11:10] != MODE_PLAIN |=> immConst == $past(rotv))
    else $error("rotated constant wrong");
  a_carry_keep: assert property (
    s_setlog ##0 pk[11:10] == MODE_PLAIN |=> carryWrite && carryOut == $past(carryFlag))
    else $error("carry not passed through");
  a_carry_msb: assert property (
    s_setlog ##0 pk[11:10] != MODE_PLAIN |=> carryWrite && carryOut == immConst[31])
    else $error("carry not taken from bit 31");
  a_dual_gate: assert property (
    s_plain ##0 (op == PB_SSAT_DUAL || op == PB_USAT_DUAL) && !dspVariant |=> undefinedInstr)
    else $error("dual saturate outside its variant");
  a_clear_pick: assert property (
    s_plain ##0 op == PB_FIELD_INS && instrHigh[3:0] == PC_REGISTER |=> opClass == CLS_FIELD_CLEAR)
    else $error("field clear not chosen");
  a_plain_unalloc: assert property (
    s_plain ##0 op == 5'h01 |=> undefinedInstr)
    else $error("unallocated code accepted");
endmodule
bind modified_immediate_decoder modified_immediate_decoder_assertions checker_inst (
  .clk(clk), .arst_n(arst_n), .instrValid(instrValid), .instrHigh(instrHigh),
  .instrLow(instrLow), .dspVariant(dspVariant), .carryFlag(carryFlag),
  .decodeValid(decodeValid), .opClass(opClass), .immConst(immConst),
  .carryOut(carryOut), .carryWrite(carryWrite), .undefinedInstr(undefinedInstr));
`default_nettype wire

// file: tb/fetch_model.sv
`timescale 1ns/100ps
`default_nettype none
module fetch_model
  import mod_imm_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Instruction and core state towards the decoder
  output logic                   instrValid,
  output logic      [HALF_W-1:0] instrHigh,
  output logic      [HALF_W-1:0] instrLow,
  output logic                   dspVariant,
  output logic                   carryFlag
);
  // Quiet lines at time zero
  initial begin
    instrValid = 1'b0;
    instrHigh  = 16'h0000;
    instrLow   = 16'h0000;
    dspVariant = 1'b0;
    carryFlag  = 1'b0;
  end
  // One-cycle request; words then flip so stale values never pass as fresh
  task automatic issue(input logic [15:0] hi, input logic [15:0] lo,
                       input logic dsp, input logic cf);
    logic rep;
    rep = hi[15:11] == TOP_PATTERN && !hi[9] && !hi[10] && !lo[14] && lo[13:12] != REP_BYTE;
    // Zero byte in a replicating mode is never fetched
    if (rep && lo[7:0] == BYTE_ZERO) return;
    @(negedge clk);
    instrValid <= 1'b1;
    instrHigh  <= hi;
    instrLow   <= lo;
    dspVariant <= dsp;
    carryFlag  <= cf;
    @(negedge clk);
    instrValid <= 1'b0;
    instrHigh  <= ~hi;
    instrLow   <= ~lo;
  endtask
endmodule
`default_nettype wire

// file: tb/modified_immediate_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none
module modified_immediate_decoder_test
  import mod_imm_pkg::*;
();
  // Decoder ports
  logic        clk = 1'b0;
  logic        arst_n;
  logic        instrValid, dspVariant, carryFlag;
  logic [15:0] instrHigh, instrLow;
  logic        decodeValid, carryOut, carryWrite, undefinedInstr, unpredictable;
  op_class_t   opClass;
  logic [31:0] immConst;
  logic [3:0]  firstOperandRegister;
  // Counters
  int          errors = 0;
  int          numChecks = 0;
  // Packed fields and hand-worked constants
  logic [11:0] packList [9] = '{12'h0ab, 12'h1ab, 12'h2ab, 12'h3ab, 12'h400,
                                12'h4ff, 12'h800, 12'hfff, 12'h7ab};
  logic [31:0] constList [9] = '{32'h000000ab, 32'h00ab00ab, 32'hab00ab00, 32'habababab,
                                 32'h80000000, 32'h7f800000, 32'h00800000, 32'h000001fe,
                                 32'h01560000};
  // 200 MHz clock
  always #2.5 clk = ~clk;
  modified_immediate_decoder modified_immediate_decoder_inst (
    .clk(clk), .arst_n(arst_n), .instrValid(instrValid), .instrHigh(instrHigh),
    .instrLow(instrLow), .dspVariant(dspVariant), .carryFlag(carryFlag),
    .decodeValid(decodeValid), .opClass(opClass), .immConst(immConst),
    .carryOut(carryOut), .carryWrite(carryWrite), .undefinedInstr(undefinedInstr),
    .unpredictable(unpredictable), .firstOperandRegister(firstOperandRegister));
  fetch_model fetch_model_inst (
    .clk(clk), .instrValid(instrValid), .instrHigh(instrHigh), .instrLow(instrLow),
    .dspVariant(dspVariant), .carryFlag(carryFlag));
  task automatic wrap_up();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Vector and class comparisons
  task automatic check_vec(input string name, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_cls(input string name, input op_class_t exp, input op_class_t got);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  // One request; returns once its result has settled
  task automatic send(input logic [15:0] hi, input logic [15:0] lo, input logic dsp, input logic cf);
    fetch_model_inst.issue(hi, lo, dsp, cf);
    check_vec("decodeValid", 32'h1, {31'h0, decodeValid});
  endtask
  // Flag-setting AND over every mode, both carry values
  task automatic t_expand();
    logic [11:0] p;
    logic        cf;
    for (int k = 0; k < 18; k++) begin
      p = packList[k / 2];
      cf = k[0];
      send({5'h1e, p[11], 1'b0, 5'h01, 4'h5}, {1'b0, p[10:8], 4'h2, p[7:0]}, 1'b0, cf);
      check_vec("immConst", constList[k / 2], immConst);
      check_vec("carryOut", {31'h0, p[11:10] == 2'h0 ? cf : constList[k / 2][31]},
                {31'h0, carryOut});
      check_vec("carryWrite", 32'h1, {31'h0, carryWrite});
      check_cls("opClass", CLS_LOGICAL, opClass);
      check_vec("firstOperandRegister", 32'h5, {28'h0, firstOperandRegister});
      check_vec("unpredictable", 32'h0, {31'h0, unpredictable});
    end
  endtask
  // Arithmetic leaves the carry alone; unknown modified opcode is undefined
  task automatic t_arith();
    send(16'hf511, 16'h0000, 1'b0, 1'b1);
    check_vec("immConst", 32'h00800000, immConst);
    check_vec("carryWrite", 32'h0, {31'h0, carryWrite});
    check_vec("carryOut", 32'h1, {31'h0, carryOut});
    check_cls("opClass", CLS_ARITH, opClass);
    send(16'hf0a0, 16'h0011, 1'b1, 1'b0);
    check_vec("undefinedInstr", 32'h1, {31'h0, undefinedInstr});
  endtask
  // Plain binary immediate row
  task automatic plain_row(input logic [4:0] op, input logic [3:0] rn, input logic [2:0] trip,
                           input logic [1:0] mid, input logic dsp, input op_class_t cls,
                           input logic undef);
    send({5'h1e, 1'b0, 1'b1, op, rn}, {1'b0, trip, 4'h1, mid, 6'h00}, dsp, 1'b0);
    check_cls("opClass", cls, opClass);
    check_vec("undefinedInstr", {31'h0, undef}, {31'h0, undefinedInstr});
    check_vec("firstOperandRegister", {28'h0, rn}, {28'h0, firstOperandRegister});
  endtask
  task automatic t_plain();
    plain_row(5'h12, 4'h2, 3'h0, 2'h0, 1'b1, CLS_DUAL_SIGNED_SATURATE, 1'b0);
    plain_row(5'h1a, 4'h2, 3'h0, 2'h0, 1'b1, CLS_DUAL_UNSIGNED_SATURATE, 1'b0);
    plain_row(5'h12, 4'h2, 3'h0, 2'h0, 1'b0, CLS_UNDEFINED, 1'b1);
    plain_row(5'h1a, 4'h2, 3'h1, 2'h0, 1'b1, CLS_UNDEFINED, 1'b1);
    plain_row(5'h12, 4'h2, 3'h0, 2'h2, 1'b1, CLS_UNDEFINED, 1'b1);
    plain_row(5'h14, 4'h3, 3'h2, 2'h1, 1'b0, CLS_SIGNED_FIELD_EXTRACT, 1'b0);
    plain_row(5'h1c, 4'h3, 3'h2, 2'h1, 1'b0, CLS_UNSIGNED_FIELD_EXTRACT, 1'b0);
    plain_row(5'h16, 4'h3, 3'h2, 2'h1, 1'b0, CLS_FIELD_INSERT, 1'b0);
    plain_row(5'h16, 4'hf, 3'h2, 2'h1, 1'b0, CLS_FIELD_CLEAR, 1'b0);
    plain_row(5'h01, 4'h3, 3'h0, 2'h0, 1'b0, CLS_UNDEFINED, 1'b1);
    plain_row(5'h1e, 4'h3, 3'h0, 2'h0, 1'b0, CLS_UNDEFINED, 1'b1);
    plain_row(5'h00, 4'h3, 3'h2, 2'h1, 1'b0, CLS_ADD_WIDE, 1'b0);
    plain_row(5'h04, 4'h3, 3'h2, 2'h1, 1'b0, CLS_MOVE_WIDE, 1'b0);
    plain_row(5'h0a, 4'h3, 3'h2, 2'h1, 1'b0, CLS_SUB_WIDE, 1'b0);
    plain_row(5'h0c, 4'h3, 3'h2, 2'h1, 1'b0, CLS_MOVE_TOP, 1'b0);
    plain_row(5'h10, 4'h3, 3'h2, 2'h1, 1'b0, CLS_SIGNED_SAT, 1'b0);
    plain_row(5'h18, 4'h3, 3'h2, 2'h1, 1'b0, CLS_UNSIGNED_SAT, 1'b0);
  endtask
  // Watchdog, far beyond the 82 cycles needed
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
  // Main sequence after eight cycles of reset
  initial begin
    arst_n = 1'b0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    t_expand();
    t_arith();
    t_plain();
    wrap_up();
  end
endmodule
`default_nettype wire
